// ---- rtl/lcdf_top.v ----
`timescale 1ns/1ps
`include "lcdf_regs.vh"
// Overview of operation
// - display select clear forces blank segments regardless of display RAM
// - display select set with activate set drives segments from display RAM contents
// - select 0x00 (bit2 ignored) gives undivided subclock
// - select 0x01 (bit2 ignored) gives subclock divided by two
// - select top 0, bit1 set gives subclock divided by four
// - select 1000 gives system clock divided by two
// - select 1100 gives system clock divided by thirty-two
// - activate clear halts controller, forces power off, registers kept
// - waveform select bit picks A or B drive style
module lcdf_top #(
    parameter NSEG = 32 // segment outputs
) (
    input wire pclk, // system clock, 50 MHz
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [`LCDF_ADDR_W-1:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output wire [31:0] prdata, // apb read data
    output wire pready, // apb ready
    output wire pslverr, // apb error on unmapped address
    input wire subclk, // subclock pin, asynchronous
    input wire [NSEG-1:0] ram_data, // display RAM pattern
    output reg [NSEG-1:0] seg_data, // segment pattern to drivers
    output reg frame_tick, // operating clock event
    output reg drive_power_on, // panel drive supply enable
    output reg waveform_type_select, // 0 = A style, 1 = B style
    output reg controller_active // controller running
);
    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    reg [7:0] panel_control_register_q;
    reg [7:0] panel_control_register_second_q;
    reg frame_tick_seen_q;
    reg [31:0] rdata_d;

    // registers sit on word boundaries, so the two low address bits must be zero
    function addr_hit;
        input [`LCDF_ADDR_W-1:0] addr;
        input [`LCDF_ADDR_W-1:0] reg_addr;
        begin
            addr_hit = (addr == reg_addr);
        end
    endfunction

    wire sel_ctrl = addr_hit(paddr, `LCDF_ADDR_CTRL);
    wire sel_ctrl2 = addr_hit(paddr, `LCDF_ADDR_CTRL2);
    wire sel_stat = addr_hit(paddr, `LCDF_ADDR_STAT);
    wire mapped = sel_ctrl | sel_ctrl2 | sel_stat;
    wire access = psel & penable;
    // a refused access never reaches a register
    wire wr = access & pwrite & mapped;
    wire wr_ctrl = wr & sel_ctrl;
    wire wr_ctrl2 = wr & sel_ctrl2;

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // status is read-only; a write to it is accepted and has no effect
    always @* begin
        rdata_d = 32'h0000_0000;
        if (sel_ctrl) begin
            rdata_d[7:0] = panel_control_register_q;
        end else if (sel_ctrl2) begin
            rdata_d[7:0] = panel_control_register_second_q;
        end else if (sel_stat) begin
            rdata_d[`LCDF_STAT_ACT] = controller_active;
            rdata_d[`LCDF_STAT_PWR] = drive_power_on;
            rdata_d[`LCDF_STAT_TICK] = frame_tick_seen_q;
        end
    end
    assign prdata = rdata_d;

    // register contents survive a halt; only reset or an APB write changes them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            panel_control_register_q <= `LCDF_CTRL_RST;
            panel_control_register_second_q <= `LCDF_CTRL2_RST;
        end else begin
            if (wr_ctrl) begin
                panel_control_register_q <= pwdata[7:0];
            end
            if (wr_ctrl2) begin
                panel_control_register_second_q <= pwdata[7:0];
            end
        end
    end

    wire controller_activate = panel_control_register_q[`LCDF_BIT_ACT];
    wire power_switch = panel_control_register_q[`LCDF_BIT_PWR];
    wire display_data_select = panel_control_register_q[`LCDF_BIT_DISPLAY_DATA_SELECT];
    wire [3:0] frame_clock_sel =
        panel_control_register_q[`LCDF_CKS_HI:`LCDF_CKS_LO];

    // ------------------------------------------------------------
    // subclock synchroniser and edge detect
    // ------------------------------------------------------------
    reg sub_s1_q;
    reg sub_s2_q;
    reg sub_s3_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else begin
            sub_s1_q <= subclk;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end

    // subclock must be well below pclk/2 for the edge detect to see it
    wire sub_rise = sub_s2_q & ~sub_s3_q;

    // ------------------------------------------------------------
    // frame clock source selection
    // ------------------------------------------------------------
    function [4:0] cks_decode;
        input [3:0] cks;
        begin
            // {source is system clock, log2 of divisor}
            // codes with the top bit clear never look at bit two
            if (!cks[3]) begin
                if (cks[1])
                    cks_decode = {1'b0, `LCDF_EXP_DIV4};
                else if (cks[0])
                    cks_decode = {1'b0, `LCDF_EXP_DIV2};
                else
                    cks_decode = {1'b0, `LCDF_EXP_DIV1};
            end else begin
                case (cks)
                    `LCDF_CKS_SYS2: cks_decode = {1'b1, `LCDF_EXP_DIV2};
                    `LCDF_CKS_SYS4: cks_decode = {1'b1, `LCDF_EXP_DIV4};
                    `LCDF_CKS_SYS8: cks_decode = {1'b1, `LCDF_EXP_DIV8};
                    `LCDF_CKS_SYS16: cks_decode = {1'b1, `LCDF_EXP_DIV16};
                    `LCDF_CKS_SYS32: cks_decode = {1'b1, `LCDF_EXP_DIV32};
                    `LCDF_CKS_SYS64: cks_decode = {1'b1, `LCDF_EXP_DIV64};
                    `LCDF_CKS_SYS128: cks_decode = {1'b1, `LCDF_EXP_DIV128};
                    default: cks_decode = {1'b1, `LCDF_EXP_DIV256};
                endcase
            end
        end
    endfunction

    wire [4:0] src_sel = cks_decode(frame_clock_sel);
    wire use_sys = src_sel[4];
    wire step = use_sys ? 1'b1 : sub_rise;
    wire [3:0] div_exp = src_sel[3:0];
    wire div_tick;

    lcdf_clk_div #(
        .W(`LCDF_DIV_W)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(controller_activate),
        .step(step),
        .exp(div_exp),
        .tick(div_tick)
    );

    // ------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_power_on <= 1'b0;
            waveform_type_select <= 1'b0;
            controller_active <= 1'b0;
        end else begin
            controller_active <= controller_activate;
            // halt overrides the power switch
            drive_power_on <= controller_activate & power_switch;
            waveform_type_select <=
                panel_control_register_second_q[`LCDF_BIT_WAVE];
        end
    end

    // ------------------------------------------------------------
    // operating clock event and status toggle
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_tick <= 1'b0;
            frame_tick_seen_q <= 1'b0;
        end else begin
            frame_tick <= div_tick;
            if (div_tick) begin
                frame_tick_seen_q <= ~frame_tick_seen_q;
            end
        end
    end

    // ------------------------------------------------------------
    // segment gating
    // ------------------------------------------------------------
    // blank while halted too, so a stopped panel never holds a stale pattern
    wire seg_enable = controller_activate & display_data_select;
    wire [NSEG-1:0] seg_d;

    genvar gi;
    generate
        for (gi = 0; gi < NSEG; gi = gi + 1) begin : g_seg
            assign seg_d[gi] = seg_enable & ram_data[gi];
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_data <= {NSEG{1'b0}};
        end else begin
            seg_data <= seg_d;
        end
    end
endmodule

// ---- rtl/lcdf_regs.vh ----
`ifndef LCDF_REGS_VH
`define LCDF_REGS_VH
// ----------------------------------------------------------------
// register map (word indices; byte address is four times the index)
// ----------------------------------------------------------------
`define LCDF_ADDR_W 18
`define LCDF_OFF_CTRL 16'hffc1
`define LCDF_OFF_CTRL2 16'hffc2
`define LCDF_OFF_STAT 16'hffc4
`define LCDF_ADDR_CTRL {`LCDF_OFF_CTRL, 2'b00}
`define LCDF_ADDR_CTRL2 {`LCDF_OFF_CTRL2, 2'b00}
`define LCDF_ADDR_STAT {`LCDF_OFF_STAT, 2'b00}
`define LCDF_STAT_ACT 0
`define LCDF_STAT_PWR 1
`define LCDF_STAT_TICK 2
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define LCDF_BIT_PWR 6
`define LCDF_BIT_ACT 5
`define LCDF_BIT_DISPLAY_DATA_SELECT 4
`define LCDF_CKS_HI 3
`define LCDF_CKS_LO 0
`define LCDF_BIT_WAVE 7
`define LCDF_CTRL_RST 8'h00
`define LCDF_CTRL2_RST 8'h00
// ----------------------------------------------------------------
// clock select codes and divisor exponents
// ----------------------------------------------------------------
`define LCDF_CKS_SYS2 4'h8
`define LCDF_CKS_SYS4 4'h9
`define LCDF_CKS_SYS8 4'ha
`define LCDF_CKS_SYS16 4'hb
`define LCDF_CKS_SYS32 4'hc
`define LCDF_CKS_SYS64 4'hd
`define LCDF_CKS_SYS128 4'he
`define LCDF_CKS_SYS256 4'hf
`define LCDF_DIV_W 8
`define LCDF_EXP_DIV1 4'h0
`define LCDF_EXP_DIV2 4'h1
`define LCDF_EXP_DIV4 4'h2
`define LCDF_EXP_DIV8 4'h3
`define LCDF_EXP_DIV16 4'h4
`define LCDF_EXP_DIV32 4'h5
`define LCDF_EXP_DIV64 4'h6
`define LCDF_EXP_DIV128 4'h7
`define LCDF_EXP_DIV256 4'h8
`endif

// ---- rtl/lcdf_clk_div.v ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// free-running divider producing one-cycle tick every 2**exp inputs
// ----------------------------------------------------------------
module lcdf_clk_div #(
    parameter W = 8
) (
    input wire pclk, // system clock
    input wire presetn, // async reset, active low
    input wire run, // counting allowed
    input wire step, // input event to divide
    input wire [3:0] exp, // log2 of divisor, 0..W
    output reg tick // one-cycle output event
);
    reg [W-1:0] cnt_q;
    wire [W-1:0] mask = ~({W{1'b1}} << exp);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= {W{1'b0}};
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (!run) begin
                cnt_q <= {W{1'b0}};
            end else if (step) begin
                // masked compare lets the divisor change without a long wrap
                if ((cnt_q & mask) == mask) begin
                    cnt_q <= {W{1'b0}};
                    tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ---- tb/lcdf_top_assertions.sv ----
`timescale 1ns/1ps
`include "lcdf_regs.vh"
module lcdf_chk #(parameter NSEG = 32) (
    input wire pclk, input wire presetn, input wire psel, input wire penable,
    input wire pwrite, input wire [`LCDF_ADDR_W-1:0] paddr, input wire [31:0] pwdata,
    input wire subclk, input wire [NSEG-1:0] ram_data, input wire [NSEG-1:0] seg_data,
    input wire frame_tick, input wire drive_power_on, input wire waveform_type_select,
    input wire controller_active
);
    // --------------------------------
    // shadow registers and period counters
    // --------------------------------
    reg [7:0] c_q, c2_q;
    reg [8:0] cyc_q, rc_q;
    reg sub_q;
    reg [1:0] tk_q;
    wire wr = psel & penable & pwrite;
    wire wc = wr && paddr == `LCDF_ADDR_CTRL;
    // the first period after a change may be partial, so wait two ticks
    wire ok = tk_q == 2'h2 && c_q[5];
    wire [8:0] sdiv = c_q[1] ? 9'h004 : (c_q[0] ? 9'h002 : 9'h001);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_q <= 8'h00; c2_q <= 8'h00; cyc_q <= 9'h000; rc_q <= 9'h000;
            sub_q <= 1'b0; tk_q <= 2'h0;
        end else begin
            if (wc) c_q <= pwdata[7:0];
            if (wr && paddr == `LCDF_ADDR_CTRL2) c2_q <= pwdata[7:0];
            sub_q <= subclk;
            cyc_q <= frame_tick ? 9'h000 : cyc_q + 9'h001;
            rc_q <= (frame_tick ? 9'h000 : rc_q) + {8'h00, subclk & ~sub_q};
            tk_q <= (wc || !c_q[5]) ? 2'h0 : tk_q + {1'b0, frame_tick && tk_q != 2'h2};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_blank; !$past(c_q[5] & c_q[4]) |-> seg_data == '0; endproperty
    a_blank: assert property (p_blank) else $error("segments not blank");
    property p_show; $past(c_q[5] & c_q[4]) |-> seg_data == $past(ram_data); endproperty
    a_show: assert property (p_show) else $error("segments differ from ram");
    property p_sub; frame_tick && ok && !c_q[3] |-> rc_q == sdiv; endproperty
    a_sub: assert property (p_sub) else $error("subclock divisor wrong");
    property p_sys2;
        frame_tick && ok && c_q[3:0] == 4'h8 |-> !$past(frame_tick) && $past(frame_tick, 2);
    endproperty
    a_sys2: assert property (p_sys2) else $error("divide by two wrong");
    property p_sys32; frame_tick && ok && c_q[3:0] == 4'hc |-> cyc_q == 9'h01f; endproperty
    a_sys32: assert property (p_sys32) else $error("divide by 32 wrong");
    property p_sysn;
        frame_tick && ok && c_q[3] |-> cyc_q == (9'h002 << c_q[2:0]) - 9'h001;
    endproperty
    a_sysn: assert property (p_sysn) else $error("system divisor wrong");
    property p_act; controller_active == $past(c_q[5]); endproperty
    a_act: assert property (p_act) else $error("active flag wrong");
    property p_pwr; drive_power_on == $past(c_q[5] & c_q[6]); endproperty
    a_pwr: assert property (p_pwr) else $error("drive power wrong");
    property p_wave; waveform_type_select == $past(c2_q[7]); endproperty
    a_wave: assert property (p_wave) else $error("waveform select wrong");
    cover property (frame_tick && ok && !c_q[3]);
    cover property (frame_tick && ok && c_q[3]);
    cover property (c_q[5] && c_q[4] && seg_data != '0);
endmodule
bind lcdf_top lcdf_chk #(.NSEG(NSEG)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .subclk(subclk),
    .ram_data(ram_data), .seg_data(seg_data), .frame_tick(frame_tick),
    .drive_power_on(drive_power_on), .waveform_type_select(waveform_type_select),
    .controller_active(controller_active));

// ---- tb/lcdf_panel.sv ----
`timescale 1ns/1ps
// panel keeps the pattern latched at each powered frame tick
module lcdf_panel (
    input wire pclk, input wire presetn, input wire [31:0] seg_data,
    input wire drive_power_on, input wire frame_tick,
    output reg [31:0] shown_q, output reg [15:0] frames_q
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shown_q <= 32'h0; frames_q <= 16'h0;
        end else if (frame_tick && drive_power_on) begin
            shown_q <= seg_data; frames_q <= frames_q + 16'h1;
        end
    end
endmodule

// ---- tb/lcdf_top_tb.sv ----
`timescale 1ns/1ps
`include "lcdf_regs.vh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); end end
module lcd_display_and_frame_clock_select_tb;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, subclk = 0, er;
    reg [`LCDF_ADDR_W-1:0] paddr = '0;
    reg [31:0] pwdata = 32'h0, ram_data = 32'h0, rd;
    wire [31:0] prdata, seg_data, shown_q;
    wire [15:0] frames_q;
    wire pready, pslverr, frame_tick, drive_power_on, waveform_type_select, controller_active;
    int fail_count = 0, checks_done = 0, n, wt;
    // code beside its tick period in pclk cycles (subclock is 13 pclk)
    logic [12:0] rows [16] = '{{4'h0, 9'h00d}, {4'h1, 9'h01a}, {4'h2, 9'h034}, {4'h3, 9'h034},
        {4'h4, 9'h00d}, {4'h5, 9'h01a}, {4'h6, 9'h034}, {4'h7, 9'h034}, {4'h8, 9'h002},
        {4'h9, 9'h004},
        {4'ha, 9'h008}, {4'hb, 9'h010}, {4'hc, 9'h020}, {4'hd, 9'h040}, {4'he, 9'h080},
        {4'hf, 9'h100}};
    lcdf_top #(.NSEG(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .subclk(subclk), .ram_data(ram_data), .seg_data(seg_data),
        .frame_tick(frame_tick), .drive_power_on(drive_power_on),
        .waveform_type_select(waveform_type_select), .controller_active(controller_active));
    lcdf_panel u_panel (.pclk(pclk), .presetn(presetn), .seg_data(seg_data),
        .drive_power_on(drive_power_on), .frame_tick(frame_tick), .shown_q(shown_q),
        .frames_q(frames_q));
    always #10 pclk = ~pclk;
    // subclock phase offset keeps its edges away from pclk edges
    initial begin #5; forever #130 subclk = ~subclk; end
    task apb(input logic w, input logic [`LCDF_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        wt = 0;
        @(posedge pclk);
        while (pready !== 1'b1) begin wt++; @(posedge pclk); end
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task next_tick(output int g);
        g = 0;
        do begin @(posedge pclk); #1; g++; end while (frame_tick !== 1'b1 && g < 2000);
    endtask
    task settle; repeat (2) @(posedge pclk); #1; endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin repeat (40000) @(posedge pclk); fail_count++; wrap_up; end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, `LCDF_ADDR_CTRL, 0); `CHK("ctrl reset", 32'h0, rd)
        `CHK("wait states", 0, wt)
        `CHK("mapped err", 1'b0, er)
        apb(0, `LCDF_ADDR_CTRL2, 0); `CHK("ctrl2 reset", 32'h0, rd)
        apb(1, 18'h00ff0, 32'h5); `CHK("unmapped err", 1'b1, er)
        $display("reset and map test done");
        foreach (rows[i]) begin
            apb(1, `LCDF_ADDR_CTRL, {24'h0, 4'h7, rows[i][12:9]});
            repeat (4) next_tick(n);
            `CHK("tick period", rows[i][8:0], n[8:0])
            $display("clock code %h done", rows[i][12:9]);
        end
        ram_data <= 32'ha5c30f96;
        apb(1, `LCDF_ADDR_CTRL, 32'h68); settle;
        `CHK("blank seg", 32'h0, seg_data)
        apb(1, `LCDF_ADDR_CTRL, 32'h78); settle;
        `CHK("shown seg", 32'ha5c30f96, seg_data)
        `CHK("active", 1'b1, controller_active)
        apb(0, `LCDF_ADDR_STAT, 0); `CHK("status run", 2'h3, rd[1:0])
        repeat (3) next_tick(n);
        `CHK("panel pattern", 32'ha5c30f96, shown_q)
        apb(1, `LCDF_ADDR_CTRL, 32'h58); settle;
        n = frames_q; repeat (20) @(posedge pclk); #1;
        `CHK("halt power", 1'b0, drive_power_on)
        `CHK("halt frames", n[15:0], frames_q)
        `CHK("halt active", 1'b0, controller_active)
        `CHK("halt seg", 32'h0, seg_data)
        apb(0, `LCDF_ADDR_STAT, 0); `CHK("status halt", 2'h0, rd[1:0])
        apb(0, `LCDF_ADDR_CTRL, 0); `CHK("ctrl kept", 32'h58, rd)
        apb(1, `LCDF_ADDR_CTRL2, 32'h80); settle;
        `CHK("wave b", 1'b1, waveform_type_select)
        $display("display and halt test done");
        presetn <= 0; repeat (3) @(posedge pclk);
        presetn <= 1; #1;
        `CHK("reset wave", 1'b0, waveform_type_select)
        `CHK("reset seg", 32'h0, seg_data)
        apb(0, `LCDF_ADDR_CTRL2, 0); `CHK("ctrl2 after reset", 32'h0, rd)
        apb(0, `LCDF_ADDR_CTRL, 0); `CHK("ctrl after reset", 32'h0, rd)
        $display("mid-run reset test done");
        wrap_up;
    end
endmodule
